// File: rtl/return_stack_pkg.sv
`default_nettype none
package return_stack_pkg;
    // ****************************************
    // widths, offsets and reset values
    // ****************************************
    localparam int ADDR_W = 10;
    localparam int PTR_W = 3;
    localparam int FLAGS_W = 5;
    localparam int DEPTH = 5;
    localparam int ROM_W = 16;
    localparam logic [3:0] RF_PTR_OFFSET = 4'h1;
    localparam logic [2:0] PTR_RESET = 3'h5;
    localparam logic [2:0] PTR_EMPTY = 3'h5;
    localparam logic [9:0] RESTART_ADDR = 10'h000;
    localparam int IRQ_NEST = 3;
    localparam logic [1:0] IRQ_CNT_RESET = 2'h0;

    // operation codes from the sequencer
    typedef enum logic [3:0] {
        OP_NONE,
        OP_CALL_DIRECT,
        OP_CALL_INDIRECT,
        OP_TABLE_FIRST,
        OP_TABLE_SECOND,
        OP_IRQ_ENTER,
        OP_SUB_EXIT,
        OP_EXIT_SKIP,
        OP_IRQ_EXIT,
        OP_PUSH_JP,
        OP_POP_JP
    } stack_op_t;

    // status flags saved on interrupt entry
    typedef struct packed {
        logic decimal_mode;
        logic compare_mode_flag;
        logic carry_flag;
        logic zero_flag;
        logic index_enable_flag;
    } status_flags_t;

    // request from the instruction sequencer
    typedef struct packed {
        stack_op_t op;
        logic [ADDR_W-1:0] program_counter;
        logic [ADDR_W-1:0] operand_addr;
        logic [ADDR_W-1:0] jump_pointer;
        logic [ADDR_W-1:0] vector_addr;
    } stack_req_t;
endpackage
`default_nettype wire

// File: rtl/cpu_return_stack.sv
// Operation
// - 3-bit pointer, five 10-bit address entries, 5-bit interrupt flag stack
// - calls, table first cycle, interrupt entry push program counter plus one
// - address-register push stores jump pointer contents instead
// - push decrements pointer first, writes entry at pointer minus one
// - returns and table second cycle load counter from entry, then increment
// - address-register pop copies entry to jump pointer, then increments
// - interrupt entry saves five flags; interrupt exit restores them
// - after saving on interrupt entry, all status bits clear to zero
// - flag stack holds three nestings; a fourth drops the earliest
// - reset loads pointer with five, the empty stack
// - pointer lives at register file location 01H
// - separate interrupt counter moves only on interrupt entry, interrupt exit and overflow reset
// - pointer above five raises internal reset
// - overflow reset restarts program execution at address 0000H
// - register file write to pointer leaves entries untouched
// - direct call loads operand only after saving return address
// - first instruction after exit-and-skip runs as no-operation
// - table second cycle moves program word to table read buffer first
// - interrupt entry loads vector address after saving state
`default_nettype none
module cpu_return_stack (
    input wire logic sys_clk_in, // instruction clock, 100 MHz
    input wire logic resetn_in, // asynchronous reset, active low
    input wire return_stack_pkg::stack_req_t req_in, // sequencer request
    input wire return_stack_pkg::status_flags_t flags_in, // live status word
    input wire logic [15:0] rom_word_in, // program word at program counter
    input wire logic rf_write_in, // register file write strobe
    input wire logic rf_read_in, // register file read strobe
    input wire logic [3:0] rf_addr_in, // register file location
    input wire logic [3:0] rf_wdata_in, // register file write data
    output logic [3:0] rf_rdata_out, // register file read data
    output logic pc_load_out, // load program counter this cycle
    output logic [9:0] pc_value_out, // value for program counter
    output logic jp_load_out, // load jump pointer register
    output logic [9:0] jp_value_out, // value for jump pointer
    output logic flags_load_out, // load status word
    output return_stack_pkg::status_flags_t flags_value_out, // status word value
    output logic [15:0] table_read_buffer_out, // table read buffer
    output logic skip_next_out, // execute next fetch as no-operation
    output logic internal_reset_out, // overflow reset request
    output logic [2:0] return_level_counter_out // current pointer
);
    // ****************************************
    // storage
    // ****************************************
    // the pointer counts down on a push; five means nothing is stacked
    // entry four is filled first, entry zero is the deepest level
    logic [2:0] return_level_counter_reg;
    logic [2:0] return_level_counter_next;
    logic [9:0] addr_stack_reg [return_stack_pkg::DEPTH];
    return_stack_pkg::status_flags_t irq_stack_reg [return_stack_pkg::IRQ_NEST];
    logic [1:0] irq_cnt_reg;
    logic [1:0] irq_cnt_next;

    // ****************************************
    // operation decode
    // ****************************************
    // decode is pure wiring so the clocked blocks stay small
    // exactly one op arrives per cycle, so the classes never overlap
    wire return_stack_pkg::stack_op_t op = req_in.op;
    wire is_call = (op == return_stack_pkg::OP_CALL_DIRECT)
        || (op == return_stack_pkg::OP_CALL_INDIRECT);
    wire is_irq_enter = (op == return_stack_pkg::OP_IRQ_ENTER);
    wire is_irq_exit = (op == return_stack_pkg::OP_IRQ_EXIT);
    wire is_push_ret = is_call || is_irq_enter
        || (op == return_stack_pkg::OP_TABLE_FIRST);
    wire is_push_jp = (op == return_stack_pkg::OP_PUSH_JP);
    wire is_push = is_push_ret || is_push_jp;
    wire is_pop_pc = (op == return_stack_pkg::OP_SUB_EXIT)
        || (op == return_stack_pkg::OP_EXIT_SKIP) || is_irq_exit
        || (op == return_stack_pkg::OP_TABLE_SECOND);
    wire is_pop_jp = (op == return_stack_pkg::OP_POP_JP);
    wire is_pop = is_pop_pc || is_pop_jp;
    wire rf_ptr_hit = (rf_addr_in == return_stack_pkg::RF_PTR_OFFSET);

    // ****************************************
    // pointer arithmetic
    // ****************************************
    // 3-bit wrap, no clipping, so 0 minus one lands on 7
    wire [2:0] ptr_dec = return_level_counter_reg - 3'h1;
    wire [2:0] ptr_inc = return_level_counter_reg + 3'h1;
    wire [9:0] return_addr = req_in.program_counter + 10'h001;
    wire [9:0] push_data = is_push_jp ? req_in.jump_pointer : return_addr;
    // an out-of-range pointer reads zero rather than garbage
    // a push from six or seven writes nothing, as overflow discards it
    wire ptr_valid = (return_level_counter_reg < return_stack_pkg::PTR_EMPTY);
    wire [9:0] top_entry = ptr_valid ? addr_stack_reg[return_level_counter_reg] : 10'h000;
    wire wr_ok = (ptr_dec < return_stack_pkg::PTR_EMPTY);
    // six or seven only come from a wrapped push, a pop at five or a stray file write
    wire overflow = (return_level_counter_reg > return_stack_pkg::PTR_EMPTY);

    // next pointer: operations win over register file writes
    // a file write in the same cycle as a stack op is dropped, not merged
    always_comb
    begin
        return_level_counter_next = return_level_counter_reg;
        if (is_push)
        begin
            return_level_counter_next = ptr_dec;
        end
        else if (is_pop)
        begin
            return_level_counter_next = ptr_inc;
        end
        else if (rf_write_in && rf_ptr_hit)
        begin
            return_level_counter_next = rf_wdata_in[2:0];
        end
    end

    // interrupt nesting counter, deaf to calls and table reads
    // counts 0, 2, 1, 0 on entries, which doubles as the slot index;
    // an exit walks the same ring backwards
    always_comb
    begin
        irq_cnt_next = irq_cnt_reg;
        if (is_irq_enter)
        begin
            irq_cnt_next = (irq_cnt_reg == 2'h0) ? 2'h2 : irq_cnt_reg - 2'h1;
        end
        else if (is_irq_exit)
        begin
            irq_cnt_next = (irq_cnt_reg == 2'h2) ? 2'h0 : irq_cnt_reg + 2'h1;
        end
    end

    // ****************************************
    // pointer and counter registers
    // ****************************************
    // overflow forces the empty value at once; entries keep their contents
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            return_level_counter_reg <= return_stack_pkg::PTR_RESET;
        end
        else if (overflow)
        begin
            return_level_counter_reg <= return_stack_pkg::PTR_RESET;
        end
        else
        begin
            return_level_counter_reg <= return_level_counter_next;
        end
    end

    // nesting counter restarts with the pointer after an overflow
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            irq_cnt_reg <= return_stack_pkg::IRQ_CNT_RESET;
        end
        else if (overflow)
        begin
            irq_cnt_reg <= return_stack_pkg::IRQ_CNT_RESET;
        end
        else
        begin
            irq_cnt_reg <= irq_cnt_next;
        end
    end

    // ****************************************
    // address stack entries
    // ****************************************
    // entries are not reset; the pointer alone says what is live
    // leaving them unreset saves a clear path on fifty flops
    for (genvar i = 0; i < return_stack_pkg::DEPTH; i++)
    begin : g_entry
        always_ff @(posedge sys_clk_in)
        begin
            if (is_push && wr_ok && (ptr_dec == 3'(i)))
            begin
                addr_stack_reg[i] <= push_data;
            end
        end
    end

    // ****************************************
    // interrupt flag stack
    // ****************************************
    // circular slots: a fourth entry overwrites the oldest
    // only three slots, so deep nesting trades old flags for area
    for (genvar j = 0; j < return_stack_pkg::IRQ_NEST; j++)
    begin : g_flags
        always_ff @(posedge sys_clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                irq_stack_reg[j] <= '0;
            end
            else if (is_irq_enter && (irq_cnt_next == 2'(j)))
            begin
                irq_stack_reg[j] <= flags_in;
            end
        end
    end

    // ****************************************
    // outputs toward the sequencer
    // ****************************************
    // selection of the values shown to the sequencer
    // an overflow overrides the counter load and value and sends the restart address
    wire table_second = (op == return_stack_pkg::OP_TABLE_SECOND);
    wire [9:0] pc_sel = overflow ? return_stack_pkg::RESTART_ADDR
        : is_pop_pc ? top_entry
        : (op == return_stack_pkg::OP_CALL_DIRECT) ? req_in.operand_addr
        : (op == return_stack_pkg::OP_CALL_INDIRECT) ? req_in.jump_pointer
        : (op == return_stack_pkg::OP_TABLE_FIRST) ? req_in.jump_pointer
        : req_in.vector_addr;
    wire pc_load_sel = overflow || is_pop_pc || is_push_ret;
    wire [3:0] rf_rdata_sel = (rf_read_in && rf_ptr_hit)
        ? {1'b0, return_level_counter_reg} : 4'h0;

    // next values of the pulses; an overflow cycle carries only the restart
    wire jp_load_sel = is_pop_jp && !overflow;
    wire flags_load_sel = (is_irq_exit || is_irq_enter) && !overflow;
    wire skip_sel = (op == return_stack_pkg::OP_EXIT_SKIP) && !overflow;
    // restore on exit, clear after save on entry
    wire return_stack_pkg::status_flags_t flags_sel = is_irq_exit
        ? irq_stack_reg[irq_cnt_reg] : '0;
    // the mirror must follow the forced empty value, not the request
    wire [2:0] level_mirror_sel = overflow ? return_stack_pkg::PTR_RESET
        : return_level_counter_next;

    // ****************************************
    // registered outputs, one cycle after the request
    // ****************************************
    // program counter load and value
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pc_load_out <= 1'b0;
            pc_value_out <= return_stack_pkg::RESTART_ADDR;
        end
        else
        begin
            pc_load_out <= pc_load_sel;
            pc_value_out <= pc_sel;
        end
    end

    // jump pointer load and value
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            jp_load_out <= 1'b0;
            jp_value_out <= 10'h000;
        end
        else
        begin
            jp_load_out <= jp_load_sel;
            jp_value_out <= top_entry;
        end
    end

    // status word restore or clear
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            flags_load_out <= 1'b0;
            flags_value_out <= '0;
        end
        else
        begin
            flags_load_out <= flags_load_sel;
            flags_value_out <= flags_sel;
        end
    end

    // table read buffer holds until the next second cycle
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            table_read_buffer_out <= 16'h0000;
        end
        else if (table_second)
        begin
            table_read_buffer_out <= rom_word_in;
        end
    end

    // skip pulse after exit-and-skip
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            skip_next_out <= 1'b0;
        end
        else
        begin
            skip_next_out <= skip_sel;
        end
    end

    // overflow reset pulse, one cycle
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            internal_reset_out <= 1'b0;
        end
        else
        begin
            internal_reset_out <= overflow;
        end
    end

    // register file read data
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rf_rdata_out <= 4'h0;
        end
        else
        begin
            rf_rdata_out <= rf_rdata_sel;
        end
    end

    // pointer mirror, equal to the pointer register after each edge
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            return_level_counter_out <= return_stack_pkg::PTR_RESET;
        end
        else
        begin
            return_level_counter_out <= level_mirror_sel;
        end
    end
endmodule
`default_nettype wire

// File: testbench/cpu_return_stack_asserts.sv
`default_nettype none
// ****************************************
// return stack port checks
// ****************************************
module cpu_return_stack_asserts (
    input wire logic sys_clk_in, // clock
    input wire logic resetn_in, // reset, active low
    input wire return_stack_pkg::stack_req_t req_in, // request
    input wire logic [15:0] rom_word_in, // program word
    input wire logic rf_write_in, // file write
    input wire logic rf_read_in, // file read
    input wire logic [3:0] rf_addr_in, // file location
    input wire logic [3:0] rf_wdata_in, // file data
    input wire logic [3:0] rf_rdata_out, // file read data
    input wire logic pc_load_out, // counter load
    input wire logic [9:0] pc_value_out, // counter value
    input wire logic flags_load_out, // status load
    input wire return_stack_pkg::status_flags_t flags_value_out, // status value
    input wire logic [15:0] table_read_buffer_out, // table buffer
    input wire logic skip_next_out, // skip pulse
    input wire logic internal_reset_out, // overflow reset
    input wire logic [2:0] return_level_counter_out // pointer
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    // op codes in package order; a pending overflow overrides any request
    wire logic ok = return_level_counter_out <= 3'h5;
    wire logic [3:0] op = req_in.op;
    wire logic [2:0] wd = rf_wdata_in[2:0];
    wire logic rf_ptr = ok && op == 4'h0 && rf_addr_in == 4'h1;
    wire logic push = ok && op inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h9};
    wire logic pop = ok && op inside {4'h4, 4'h6, 4'h7, 4'h8, 4'ha};
    over_reset_a: assert property (!ok |=> internal_reset_out && return_level_counter_out == 3'h5)
        else $error("overflow did not reset the pointer");
    restart_addr_a: assert property (internal_reset_out |-> pc_load_out && pc_value_out == 10'h000)
        else $error("overflow restart address wrong");
    push_ptr_a: assert property (push |=> return_level_counter_out == $past(return_level_counter_out) - 3'h1)
        else $error("push did not decrement pointer");
    pop_ptr_a: assert property (pop |=> return_level_counter_out == $past(return_level_counter_out) + 3'h1)
        else $error("pop did not increment pointer");
    call_target_a: assert property (ok && op == 4'h1 |=> pc_load_out && pc_value_out == $past(req_in.operand_addr))
        else $error("call target not loaded");
    irq_entry_a: assert property (ok && op == 4'h5 |=> flags_load_out && flags_value_out == 5'h00 && pc_value_out == $past(req_in.vector_addr))
        else $error("interrupt entry wrong");
    skip_pulse_a: assert property (ok && op == 4'h7 |=> skip_next_out)
        else $error("no skip after exit and skip");
    table_buf_a: assert property (ok && op == 4'h4 |=> table_read_buffer_out == $past(rom_word_in))
        else $error("table buffer not loaded");
    ptr_read_a: assert property (rf_ptr && rf_read_in |=> rf_rdata_out == {1'b0, $past(return_level_counter_out)})
        else $error("pointer read wrong");
    ptr_write_a: assert property (rf_ptr && rf_write_in |=> return_level_counter_out == $past(wd))
        else $error("pointer write wrong");
endmodule
bind cpu_return_stack cpu_return_stack_asserts u_asserts (.sys_clk_in, .resetn_in, .req_in,
    .rom_word_in, .rf_write_in, .rf_read_in, .rf_addr_in, .rf_wdata_in, .rf_rdata_out,
    .pc_load_out, .pc_value_out, .flags_load_out, .flags_value_out, .table_read_buffer_out,
    .skip_next_out, .internal_reset_out, .return_level_counter_out);
`default_nettype wire

// File: testbench/seq_model.sv
`default_nettype none
// ****************************************
// instruction sequencer stand-in
// ****************************************
module seq_model (
    input wire logic sys_clk_in, // clock
    input wire logic resetn_in, // reset, active low
    input wire return_stack_pkg::stack_op_t op_in, // op to issue
    input wire logic [9:0] addr_in, // operand and vector address
    input wire logic jp_load_in, // stack loads jump pointer
    input wire logic [9:0] jp_value_in, // jump pointer value
    output return_stack_pkg::stack_req_t req_out // request to stack
);
    logic [9:0] pc_reg;
    logic [9:0] jp_reg;
    wire logic [9:0] jp_now = jp_load_in ? jp_value_in : jp_reg;
    // free counter keeps return addresses independent of the stack
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pc_reg <= 10'h000;
            jp_reg <= 10'h000;
        end
        else
        begin
            pc_reg <= pc_reg + 10'h001;
            jp_reg <= jp_now;
        end
    end
    // bypass so a jump pointer pop followed at once by a use sees the new jump pointer
    assign req_out = '{op_in, pc_reg, addr_in, jp_now, addr_in};
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic rf_write_in = 1'b0;
    logic rf_read_in = 1'b0;
    logic [3:0] rf_addr_in = 4'h1;
    logic [3:0] rf_wdata_in = 4'h0;
    logic [9:0] addr = 10'h000;
    logic [15:0] rom_word_in = 16'h0000;
    logic [31:0] seed = 32'h9afc;
    return_stack_pkg::stack_op_t op = return_stack_pkg::OP_NONE;
    return_stack_pkg::status_flags_t flags_in = 5'h00;
    return_stack_pkg::status_flags_t flags_value_out;
    return_stack_pkg::stack_req_t req;
    logic [3:0] rf_rdata_out;
    logic pc_load_out, jp_load_out, flags_load_out, rd_was, tb_was;
    logic skip_next_out, internal_reset_out;
    logic [15:0] table_read_buffer_out;
    logic [9:0] pc_value_out, jp_value_out, jp = 10'h000;
    logic [2:0] return_level_counter_out;
    logic [15:0] q_pc[$], q_jp[$], q_fl[$], q_rd[$], q_tb[$], q_sk[$], q_ir[$];
    logic [9:0] ent[8];
    logic [4:0] fst[$];
    int ptr = 5;
    int fails = 0;
    int total_checks = 0;
    int seq_a[] = '{5, 6, 5, 6, 5, 6, 5, 6, 1, 10, 9, 9, 9, 8, 8, 8};
    int seq_b[] = '{6, 6, 3, 4, 1, 7, 2, 9, 10};
    seq_model u_seq (.sys_clk_in, .resetn_in, .op_in(op), .addr_in(addr),
        .jp_load_in(jp_load_out), .jp_value_in(jp_value_out), .req_out(req));
    cpu_return_stack u_dut (.sys_clk_in, .resetn_in, .req_in(req), .flags_in, .rom_word_in,
        .rf_write_in, .rf_read_in, .rf_addr_in, .rf_wdata_in, .rf_rdata_out, .pc_load_out,
        .pc_value_out, .jp_load_out, .jp_value_out, .flags_load_out, .flags_value_out,
        .table_read_buffer_out, .skip_next_out, .internal_reset_out,
        .return_level_counter_out);
    initial
    begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check_value(input logic [15:0] got, ref logic [15:0] q[$]);
        total_checks++;
        if (q.size() == 0 || got !== q.pop_front())
        begin
            fails++;
            $display("wrong value at %0t: got %h", $time, got);
        end
    endtask
    task automatic finish_test;
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // drivers; op codes follow package order
    // ****************************************
    task automatic rf_access(input logic wr, input logic [3:0] d);
        @(posedge sys_clk_in);
        #1;
        op = return_stack_pkg::OP_NONE;
        rf_write_in = wr;
        rf_read_in = !wr;
        rf_wdata_in = d;
        if (wr)
            ptr = d;
        else
            q_rd.push_back({13'h0000, ptr[2:0]});
    endtask
    task automatic do_op(input int k);
        @(posedge sys_clk_in);
        #1;
        seed = lfsr(seed);
        if (k inside {4, 6, 7, 8, 10} && (ptr >= 5 || (k == 8 && fst.size() == 0)))
            k = 1; // popping an empty stack is undefined
        op = return_stack_pkg::stack_op_t'(k);
        rf_write_in = 1'b0;
        rf_read_in = 1'b0;
        addr = seed[9:0];
        flags_in = seed[14:10];
        rom_word_in = seed[31:16];
        if (k inside {1, 2, 3, 5, 9})
        begin
            ptr = (ptr + 7) % 8;
            ent[ptr] = (k == 9) ? jp : req.program_counter + 10'h001;
            if (k != 9)
                q_pc.push_back({6'h00, (k inside {2, 3}) ? jp : addr});
            if (k == 5)
            begin
                fst.push_back(flags_in);
                if (fst.size() > 3)
                    void'(fst.pop_front());
                q_fl.push_back(16'h0000);
            end
        end
        else if (k != 0)
        begin
            if (k == 10)
                q_jp.push_back({6'h00, ent[ptr]});
            else
                q_pc.push_back({6'h00, ent[ptr]});
            jp = (k == 10) ? ent[ptr] : jp;
            if (k == 8)
                q_fl.push_back({11'h000, fst.pop_back()});
            if (k == 4)
                q_tb.push_back(rom_word_in);
            if (k == 7)
                q_sk.push_back(16'h0001);
            ptr = ptr + 1;
        end
        if (ptr > 5)
        begin
            q_pc.push_back(16'h0000);
            q_ir.push_back(16'h0001);
            ptr = 5;
            fst.delete();
            @(posedge sys_clk_in);
            #1;
            op = return_stack_pkg::OP_NONE;
        end
    endtask
    // results checked against the oldest note when they appear
    always @(posedge sys_clk_in)
    begin
        rd_was = rf_read_in;
        tb_was = (op == return_stack_pkg::OP_TABLE_SECOND);
        #2;
        if (pc_load_out !== 1'b0) check_value({6'h00, pc_value_out}, q_pc);
        if (jp_load_out !== 1'b0) check_value({6'h00, jp_value_out}, q_jp);
        if (flags_load_out !== 1'b0) check_value({11'h000, flags_value_out}, q_fl);
        if (rd_was) check_value({12'h000, rf_rdata_out}, q_rd);
        if (tb_was) check_value(table_read_buffer_out, q_tb);
        if (skip_next_out !== 1'b0) check_value({15'h0000, skip_next_out}, q_sk);
        if (internal_reset_out !== 1'b0) check_value({15'h0000, internal_reset_out}, q_ir);
    end
    // main sequence: nesting, pointer write, random mix, overflow
    initial
    begin
        repeat (2) @(posedge sys_clk_in);
        #1;
        resetn_in = 1'b1;
        rf_access(1'b0, 4'h0);
        foreach (seq_a[i]) do_op(seq_a[i]);
        rf_access(1'b1, 4'h3);
        foreach (seq_b[i]) do_op(seq_b[i]);
        repeat (300)
        begin
            seed = lfsr(seed);
            do_op(int'(seed % 11));
        end
        repeat (6) do_op(1);
        do_op(0);
        rf_access(1'b0, 4'h0);
        do_op(0);
        do_op(0);
        if (q_pc.size() + q_jp.size() + q_fl.size() + q_rd.size()
            + q_tb.size() + q_sk.size() + q_ir.size() != 0)
        begin
            fails++;
            $display("wrong value at %0t: expected results missing", $time);
        end
        finish_test();
    end
endmodule
`default_nettype wire
